// File: design/flow_decoder.sv
/*
 decode and program-flow logic: two-word instructions, skips,
 computed jump on the pc low byte, pc holding latches, table access.
 assumes fetch presents one word per valid cycle and execute
 supplies file data, working register and table memory bytes.
*/
// How it works
// - four two-word ops: file move, call, goto, load pointer
// - second words carry 1111 prefix and decode as special no-op
// - low twelve bits of second word are operand data
// - first word executed means second word fetched and used
// - a lone second word does nothing and changes no state
// - file move is 1100 first word, destination in second word
// - test-skip-if-zero skips next word when tested data is zero
// - adding working register to pc low byte jumps by bytes
// - that add leaves the high and upper holding latches alone
// - reading pc low byte copies pc high/upper into latches
// - return-with-literal returns with immediate in working reg
// - table pointer addresses program memory by byte
// - each table access moves exactly one byte
// - skip over a two-word instruction costs three cycles total
`timescale 1ns/100ps
`default_nettype none
module flow_decoder
    import flow_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // fetch path
    input wire logic word_valid_in,
    input wire logic [WORD_W-1:0] word_in,
    // execute-side operands
    input wire logic [7:0] file_data_in,
    input wire logic [7:0] working_in,
    input wire logic [PC_W-1:0] return_pc_in,
    input wire logic [7:0] prog_byte_in,
    input wire logic [TP_W-1:0] table_pointer_in,
    input wire logic [7:0] table_latch_in,
    // program flow
    output logic [PC_W-1:0] pc_out,
    output logic [7:0] pc_high_holding_latch_out,
    output logic [7:0] pc_upper_holding_latch_out,
    output logic [7:0] pc_low_read_out,
    // executed instruction
    output logic exec_out,
    output logic [WORD_W-1:0] first_word_out,
    output logic [11:0] operand_out,
    output logic two_word_out,
    output logic nop_out,
    output logic skip_out,
    output logic return_out,
    output logic [7:0] working_wr_out,
    output logic working_we_out,
    // table access
    output logic tbl_rd_out,
    output logic tbl_wr_out,
    output logic [TP_W-1:0] tbl_addr_out,
    output logic [7:0] tbl_wdata_out,
    output logic [7:0] table_latch_out
);
    typedef enum logic [1:0] {
        ST_FIRST = 2'b00,
        ST_SECOND = 2'b01,
        ST_SKIP = 2'b10,
        ST_SKIP2 = 2'b11
    } dec_state_t;

    function automatic logic is_two_word(input logic [WORD_W-1:0] w);
        is_two_word = (w[15:12] == OP_FILE_MOVE)
            || (w[15:9] == OP_CALL_HI7)
            || (w[15:8] == OP_GOTO)
            || ((w[15:8] == OP_LOAD_FSP) && (w[7:6] == LOAD_FSP_SUB));
    endfunction

    dec_state_t st_r, st_nxt;
    logic [PC_W-1:0] pc_r, pc_nxt;
    logic [7:0] plh_r, plh_nxt, plu_r, plu_nxt, lo_rd_r, lo_rd_nxt;
    logic exec_r, exec_nxt, tw_r, tw_nxt, nop_r, nop_nxt;
    logic skip_r, skip_nxt, ret_r, ret_nxt, wwe_r, wwe_nxt;
    logic [WORD_W-1:0] fw_r, fw_nxt;
    logic [11:0] oper_r, oper_nxt;
    logic [7:0] wwr_r, wwr_nxt, tlat_r, tlat_nxt, twd_r, twd_nxt;
    logic trd_r, trd_nxt, twr_r, twr_nxt;
    logic [TP_W-1:0] tad_r, tad_nxt;
    logic hold_load;
    logic [WORD_W-1:0] held_word;

    word_buf u_hold (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .load_in(hold_load),
        .word_in(word_in),
        .word_out(held_word)
    );

    always_comb begin
        st_nxt = st_r;
        pc_nxt = pc_r;
        plh_nxt = plh_r;
        plu_nxt = plu_r;
        lo_rd_nxt = lo_rd_r;
        exec_nxt = 1'b0;
        tw_nxt = 1'b0;
        nop_nxt = 1'b0;
        skip_nxt = 1'b0;
        ret_nxt = 1'b0;
        wwe_nxt = 1'b0;
        wwr_nxt = wwr_r;
        fw_nxt = fw_r;
        oper_nxt = oper_r;
        tlat_nxt = tlat_r;
        twd_nxt = twd_r;
        trd_nxt = 1'b0;
        twr_nxt = 1'b0;
        tad_nxt = tad_r;
        hold_load = 1'b0;
        if (word_valid_in) begin
            pc_nxt = pc_r + PC_W'(2);
            unique case (st_r)
                ST_FIRST: begin
                    if (is_two_word(word_in)) begin
                        hold_load = 1'b1;
                        st_nxt = ST_SECOND;
                    end else if (word_in[15:12] == OP_SECOND_WORD) begin
                        nop_nxt = 1'b1;
                        exec_nxt = 1'b1;
                        fw_nxt = word_in;
                    end else begin
                        exec_nxt = 1'b1;
                        fw_nxt = word_in;
                        if (word_in[15:9] == OP_TEST_SKIP_ZERO
                                && file_data_in == BYTE_RESET) begin
                            skip_nxt = 1'b1;
                            st_nxt = ST_SKIP;
                        end
                        if (word_in[15:10] == OP_ADD_WORKING
                                && word_in[9]
                                && word_in[7:0] == PC_LOW_FILE_ADDR) begin
                            pc_nxt = pc_r + PC_W'(2) + PC_W'(working_in);
                        end
                        if (word_in[15:8] == OP_MOVE_FROM_FILE_HI
                                && word_in[7:0] == PC_LOW_FILE_ADDR) begin
                            lo_rd_nxt = pc_r[7:0];
                            plh_nxt = pc_r[15:8];
                            plu_nxt = {3'h0, pc_r[20:16]};
                        end
                        if (word_in[15:8] == OP_RETURN_LIT) begin
                            ret_nxt = 1'b1;
                            wwe_nxt = 1'b1;
                            wwr_nxt = word_in[7:0];
                            pc_nxt = return_pc_in;
                        end
                        if (word_in == OP_TABLE_READ) begin
                            trd_nxt = 1'b1;
                            tad_nxt = table_pointer_in;
                            tlat_nxt = prog_byte_in;
                        end
                        if (word_in == OP_TABLE_WRITE) begin
                            twr_nxt = 1'b1;
                            tad_nxt = table_pointer_in;
                            twd_nxt = table_latch_in;
                        end
                    end
                end
                ST_SECOND: begin
                    exec_nxt = 1'b1;
                    tw_nxt = 1'b1;
                    fw_nxt = held_word;
                    oper_nxt = word_in[11:0];
                    st_nxt = ST_FIRST;
                    if (held_word[15:8] == OP_GOTO
                            || held_word[15:9] == OP_CALL_HI7) begin
                        pc_nxt = {word_in[11:0], held_word[7:0], 1'b0};
                    end
                end
                ST_SKIP: begin
                    nop_nxt = 1'b1;
                    exec_nxt = 1'b1;
                    fw_nxt = NOP_WORD;
                    st_nxt = is_two_word(word_in) ? ST_SKIP2 : ST_FIRST;
                end
                ST_SKIP2: begin
                    nop_nxt = 1'b1;
                    exec_nxt = 1'b1;
                    fw_nxt = NOP_WORD;
                    st_nxt = ST_FIRST;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_r <= ST_FIRST;
            pc_r <= PC_RESET;
            plh_r <= BYTE_RESET;
            plu_r <= BYTE_RESET;
            lo_rd_r <= BYTE_RESET;
            exec_r <= 1'b0;
            tw_r <= 1'b0;
            nop_r <= 1'b0;
            skip_r <= 1'b0;
            ret_r <= 1'b0;
            wwe_r <= 1'b0;
            wwr_r <= BYTE_RESET;
            fw_r <= NOP_WORD;
            oper_r <= OPER_RESET;
            tlat_r <= BYTE_RESET;
            twd_r <= BYTE_RESET;
            trd_r <= 1'b0;
            twr_r <= 1'b0;
            tad_r <= TP_RESET;
        end else begin
            st_r <= st_nxt;
            pc_r <= pc_nxt;
            plh_r <= plh_nxt;
            plu_r <= plu_nxt;
            lo_rd_r <= lo_rd_nxt;
            exec_r <= exec_nxt;
            tw_r <= tw_nxt;
            nop_r <= nop_nxt;
            skip_r <= skip_nxt;
            ret_r <= ret_nxt;
            wwe_r <= wwe_nxt;
            wwr_r <= wwr_nxt;
            fw_r <= fw_nxt;
            oper_r <= oper_nxt;
            tlat_r <= tlat_nxt;
            twd_r <= twd_nxt;
            trd_r <= trd_nxt;
            twr_r <= twr_nxt;
            tad_r <= tad_nxt;
        end
    end

    assign pc_out = pc_r;
    assign pc_high_holding_latch_out = plh_r;
    assign pc_upper_holding_latch_out = plu_r;
    assign pc_low_read_out = lo_rd_r;
    assign exec_out = exec_r;
    assign first_word_out = fw_r;
    assign operand_out = oper_r;
    assign two_word_out = tw_r;
    assign nop_out = nop_r;
    assign skip_out = skip_r;
    assign return_out = ret_r;
    assign working_wr_out = wwr_r;
    assign working_we_out = wwe_r;
    assign tbl_rd_out = trd_r;
    assign tbl_wr_out = twr_r;
    assign tbl_addr_out = tad_r;
    assign tbl_wdata_out = twd_r;
    assign table_latch_out = tlat_r;
endmodule
`default_nettype wire

// File: design/flow_pkg.sv
/*
 package of the fetch/decode flow block: opcode prefixes, widths,
 reset values. assumes a 16-bit program word and 21-bit byte pc.
*/
package flow_pkg;
    localparam int WORD_W = 16;
    localparam int PC_W = 21;
    localparam int TP_W = 22;
    // first- and second-word opcode prefixes of the two-word instructions
    localparam logic [3:0] OP_FILE_MOVE = 4'hC;
    localparam logic [3:0] OP_SECOND_WORD = 4'hF;
    localparam logic [7:0] OP_CALL_HI = 8'hEC;
    localparam logic [6:0] OP_CALL_HI7 = 7'h76;
    localparam logic [7:0] OP_GOTO = 8'hEF;
    localparam logic [7:0] OP_LOAD_FSP = 8'hEE;
    localparam logic [1:0] LOAD_FSP_SUB = 2'h0;
    // single-word instructions handled here
    localparam logic [6:0] OP_TEST_SKIP_ZERO = 7'h33;
    localparam logic [5:0] OP_ADD_WORKING = 6'h09;
    localparam logic [7:0] OP_RETURN_LIT = 8'h0C;
    localparam logic [7:0] OP_MOVE_FROM_FILE_HI = 8'h50;
    localparam logic [15:0] OP_TABLE_READ = 16'h0008;
    localparam logic [15:0] OP_TABLE_WRITE = 16'h000C;
    localparam logic [7:0] PC_LOW_FILE_ADDR = 8'hF9;
    localparam logic [WORD_W-1:0] NOP_WORD = 16'h0000;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [TP_W-1:0] TP_RESET = 22'h000000;
    localparam logic [11:0] OPER_RESET = 12'h000;
endpackage

// File: design/word_buf.sv
/*
 holds the first word of a two-word instruction until its second
 word arrives. assumes single clock, async active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module word_buf
    import flow_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // write side
    input wire logic load_in,
    input wire logic [WORD_W-1:0] word_in,
    // held word
    output logic [WORD_W-1:0] word_out
);
    logic [WORD_W-1:0] word_r;
    logic [WORD_W-1:0] word_nxt;

    always_comb begin
        word_nxt = load_in ? word_in : word_r;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            word_r <= NOP_WORD;
        end else begin
            word_r <= word_nxt;
        end
    end

    assign word_out = word_r;
endmodule
`default_nettype wire

// File: test/flow_monitor.sv
/* checker of flow_decoder port timing.
 assumes bind to flow_decoder; outputs land at the take edge. */
`timescale 1ns/100ps
`default_nettype none
module flow_monitor
    import flow_pkg::*;
(
    // watched ports
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [WORD_W-1:0] word_in,
    input wire logic [7:0] file_data_in,
    input wire logic [7:0] working_in,
    input wire logic [PC_W-1:0] return_pc_in,
    input wire logic [PC_W-1:0] pc_out,
    input wire logic [7:0] pc_high_holding_latch_out,
    input wire logic [7:0] pc_upper_holding_latch_out,
    input wire logic exec_out,
    input wire logic [WORD_W-1:0] first_word_out,
    input wire logic [11:0] operand_out,
    input wire logic two_word_out,
    input wire logic nop_out,
    input wire logic skip_out,
    input wire logic return_out,
    input wire logic [7:0] working_wr_out,
    input wire logic working_we_out
);
    default clocking mon_cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    chk_two_word_kind: assert property (
        two_word_out |-> first_word_out[15:12] == OP_FILE_MOVE
        || first_word_out[15:9] == OP_CALL_HI7
        || first_word_out[15:8] == OP_GOTO
        || first_word_out[15:6] == {OP_LOAD_FSP, LOAD_FSP_SUB})
        else $error("bad pair");
    chk_second_word: assert property (
        two_word_out |-> $past(word_in) == {OP_SECOND_WORD, operand_out})
        else $error("second word wrong");
    chk_goto_target: assert property (
        two_word_out && first_word_out[15:8] == OP_GOTO |->
        pc_out == {operand_out, first_word_out[7:0], 1'b0})
        else $error("goto pc");
    chk_nop_quiet: assert property (
        nop_out |-> exec_out && !two_word_out && !return_out && !working_we_out
        && $stable(pc_high_holding_latch_out)) else $error("nop changed state");
    chk_skip_zero: assert property (
        exec_out && !nop_out && first_word_out[15:9] == OP_TEST_SKIP_ZERO |->
        skip_out == ($past(file_data_in) == 8'h00)) else $error("skip wrong");
    chk_pc_low_add: assert property (
        exec_out && !nop_out && first_word_out[15:9] == {OP_ADD_WORKING, 1'b1}
        && first_word_out[7:0] == PC_LOW_FILE_ADDR |->
        pc_out == $past(pc_out) + 21'h2 + $past(working_in)
        && $stable(pc_high_holding_latch_out)
        && $stable(pc_upper_holding_latch_out))
        else $error("computed jump wrong");
    chk_pc_low_read: assert property (
        exec_out && !nop_out
        && first_word_out == {OP_MOVE_FROM_FILE_HI, PC_LOW_FILE_ADDR} |->
        {pc_upper_holding_latch_out, pc_high_holding_latch_out}
        == {3'b000, 13'($past(pc_out) >> 8)}) else $error("latch copy wrong");
    chk_return_lit: assert property (
        return_out |-> working_we_out && working_wr_out == first_word_out[7:0]
        && pc_out == $past(return_pc_in)) else $error("return wrong");
    cover property (skip_out);
    cover property (two_word_out);
    cover property (return_out);
endmodule
`default_nettype wire

// File: test/prog_mem.sv
/* program memory model read by byte for table access.
 assumes a combinational byte read at the table pointer. */
`timescale 1ns/100ps
`default_nettype none
module prog_mem
    import flow_pkg::*;
(
    // byte address and byte read
    input wire logic [TP_W-1:0] addr_in,
    output logic [7:0] byte_out
);
    // two bytes per word, low byte at the even address
    assign byte_out = addr_in[0] ? addr_in[8:1] ^ 8'hA5
        : addr_in[8:1];
endmodule
`default_nettype wire

// File: test/tb_flow_decoder.sv
/* self-checking bench of flow_decoder with program memory model.
 assumes flow_pkg, design, prog_mem and flow_monitor compiled. */
`timescale 1ns/100ps
`default_nettype none
module tb_flow_decoder
    import flow_pkg::*;
;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, word_valid_in = 1'b0;
    logic exec_out, two_word_out, nop_out, skip_out, return_out;
    logic working_we_out, tbl_rd_out, tbl_wr_out;
    logic [WORD_W-1:0] word_in = 16'h0000, first_word_out, w1;
    logic [7:0] file_data_in = 8'h00, working_in = 8'h00;
    logic [7:0] table_latch_in = 8'h00;
    logic [7:0] prog_byte_in, pc_low_read_out, working_wr_out, tbl_wdata_out;
    logic [7:0] pc_high_holding_latch_out, pc_upper_holding_latch_out;
    logic [7:0] table_latch_out;
    logic [PC_W-1:0] return_pc_in = 21'h000000, pc_out;
    logic [TP_W-1:0] table_pointer_in = 22'h000000, tbl_addr_out;
    logic [11:0] operand_out, n;
    logic [7:0] tw [5] = '{8'hC1, 8'hEC, 8'hED, 8'hEF, 8'hEE};
    int failures = 0, tests_run = 0, seed = 32'h64C2, i;
    wire [15:0] latches = {pc_upper_holding_latch_out,
        pc_high_holding_latch_out};
    flow_decoder flow_decoder_i (.*);
    prog_mem prog_mem_i (.addr_in(table_pointer_in), .byte_out(prog_byte_in));
    always #5 clk_in = ~clk_in;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one word per call from a falling edge, a random stall before some
    task automatic issue(input logic [15:0] w);
        if ($random(seed) % 4 == 0) begin
            word_valid_in = 1'b0;
            word_in = 16'($random(seed));
            @(negedge clk_in);
        end
        word_valid_in = 1'b1;
        word_in = w;
        @(posedge clk_in);
        @(negedge clk_in);
    endtask
    function automatic logic [7:0] mem_byte(input logic [TP_W-1:0] a);
        return a[0] ? a[8:1] ^ 8'hA5 : a[8:1];
    endfunction
    task automatic finish_test();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        @(negedge clk_in);
        sys_rst_in = 1'b0;
        chk({pc_out, exec_out, table_latch_out}, 32'h0);
        $display("reset test done");
        for (i = 0; i < 10; i++) begin
            w1 = {tw[i % 5], 2'b00, 6'($random(seed))};
            n = 12'($random(seed));
            issue(w1);
            chk(exec_out, 1'b0);
            issue({OP_SECOND_WORD, n});
            chk({exec_out, two_word_out, nop_out}, 3'b110);
            chk({first_word_out, operand_out}, {w1, n});
        end
        issue({OP_SECOND_WORD, 12'hABC});
        chk({exec_out, nop_out, two_word_out}, 3'b110);
        $display("two-word test done");
        for (i = 0; i < 2; i++) begin
            file_data_in = i ? 8'($random(seed)) | 8'h01 : 8'h00;
            issue(16'hEF10);
            issue({OP_SECOND_WORD, 12'h000});
            issue(16'h6600);
            chk({exec_out, skip_out}, {1'b1, i == 0});
            issue(16'hC123);
            chk({exec_out, nop_out}, {i == 0, i == 0});
            issue(16'hF456);
            chk({exec_out, nop_out, two_word_out},
                {1'b1, i == 0, i > 0});
            chk(pc_out, 21'h000026);
        end
        $display("skip test done");
        for (i = 0; i < 4; i++) begin
            w1 = {OP_GOTO, 2'b00, 6'($random(seed))};
            n = 12'($random(seed));
            issue(w1);
            issue({OP_SECOND_WORD, n});
            issue({OP_MOVE_FROM_FILE_HI, PC_LOW_FILE_ADDR});
            chk(pc_low_read_out, {w1[6:0], 1'b0});
            chk(latches, {3'b000, n, 1'b0});
            issue(w1);
            issue({OP_SECOND_WORD, ~n});
            working_in = 8'(2 * i);
            issue(16'h26F9);
            chk(pc_out, {~n, w1[7:0], 1'b0} + 2 + 2 * i);
            chk(latches, {3'b000, n, 1'b0});
            return_pc_in = 21'($random(seed));
            issue({OP_RETURN_LIT, w1[7:0]});
            chk({return_out, working_we_out}, 2'b11);
            chk({working_wr_out, pc_out}, {w1[7:0], return_pc_in});
        end
        $display("jump test done");
        for (i = 0; i < 6; i++) begin
            table_pointer_in = {21'($random(seed)), i[0]};
            table_latch_in = 8'($random(seed));
            issue(OP_TABLE_READ);
            chk({tbl_rd_out, tbl_wr_out}, 2'b10);
            chk(table_latch_out, mem_byte(table_pointer_in));
            chk(tbl_addr_out, table_pointer_in);
            issue(OP_TABLE_WRITE);
            chk({tbl_wr_out, tbl_rd_out, tbl_wdata_out},
                {2'b10, table_latch_in});
            chk(table_latch_out, mem_byte(table_pointer_in));
        end
        $display("table test done");
        finish_test();
    end
endmodule
bind flow_decoder flow_monitor flow_monitor_i (.*);
`default_nettype wire
